//--- src/ppfm_top.sv
/*
  Pin function multiplexer for ports K, AD, M, P, Q and S.
  Assumes GPIO data/direction, mode bits and peripheral signals are
  on i_core_clk; pin levels are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module ppfm_top (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // mode and control
    input wire logic i_expanded_mode,
    input wire logic i_ext_bus_portk_enable,
    input wire logic i_portk_pullup_enable,
    // external bus
    input wire logic i_emulation_chip_select_n,
    input wire logic i_external_chip_select_n,
    input wire logic [5:0] i_extended_address_bits,
    output logic o_internal_rom_enable,
    // port K
    input wire logic [7:0] i_portk_pin,
    output logic [7:0] o_portk_pin,
    output logic [7:0] o_portk_oe,
    output logic [7:0] o_portk_pullup,
    input wire logic [7:0] i_portk_dout,
    input wire logic [7:0] i_portk_dir,
    output logic [7:0] o_portk_din,
    // port AD
    input wire logic [15:0] i_portad_pin,
    output logic [15:0] o_portad_pin,
    output logic [15:0] o_portad_oe,
    input wire logic [15:0] i_portad_dout,
    input wire logic [15:0] i_portad_dir,
    input wire logic [15:0] i_portad_digital_en,
    output logic [15:0] o_portad_din,
    input wire logic [15:0] i_analog_port_wakeup_en,
    output logic [15:0] o_key_wakeup,
    // port M
    input wire logic [7:0] i_portm_pin,
    output logic [7:0] o_portm_pin,
    output logic [7:0] o_portm_oe,
    input wire logic [7:0] i_portm_dout,
    input wire logic [7:0] i_portm_dir,
    output logic [7:0] o_portm_din,
    // two-wire bus
    input wire logic i_iic_enable,
    input wire logic i_iic_scl_drive_low,
    input wire logic i_iic_sda_drive_low,
    output logic o_iic_scl,
    output logic o_iic_sda,
    // serial 2
    input wire logic i_serial2_tx_enable,
    input wire logic i_serial2_transmit,
    input wire logic i_serial2_rx_enable,
    output logic o_serial2_receive,
    // converters
    input wire logic i_converter1_enable,
    input wire logic i_converter2_enable,
    output logic [1:0] o_portm_analog_sel,
    // port P
    input wire logic [5:0] i_portp_pin,
    output logic [5:0] o_portp_pin,
    output logic [5:0] o_portp_oe,
    input wire logic [5:0] i_portp_dout,
    input wire logic [5:0] i_portp_dir,
    output logic [5:0] o_portp_din,
    // fault protected pwm
    input wire logic i_fault_protected_pwm_enable,
    input wire logic i_fault_pwm_pair_mode,
    input wire logic [2:0] i_fault_pwm_pair_en,
    input wire logic [5:0] i_fault_pwm_outputs,
    input wire logic i_current_status_enable,
    input wire logic [3:0] i_fault_input_enable,
    output logic [2:0] o_current_status_inputs_n,
    output logic [3:0] o_fault_inputs,
    // port Q
    input wire logic [6:0] i_portq_pin,
    output logic [6:0] o_portq_pin,
    output logic [6:0] o_portq_oe,
    input wire logic [6:0] i_portq_dout,
    input wire logic [6:0] i_portq_dir,
    output logic [6:0] o_portq_din,
    // port S
    input wire logic [7:0] i_ports_pin,
    output logic [7:0] o_ports_pin,
    output logic [7:0] o_ports_oe,
    input wire logic [7:0] i_ports_dout,
    input wire logic [7:0] i_ports_dir,
    output logic [7:0] o_ports_din,
    // spi
    input wire logic i_spi_enable,
    input wire logic i_spi_master,
    input wire logic i_spi_ss_output_enable,
    input wire logic i_spi_ss_n,
    input wire logic i_spi_sck,
    input wire logic i_spi_mosi,
    output logic o_spi_ss_n,
    output logic o_spi_sck,
    output logic o_spi_mosi
);
    ppfm_pkg::ppfm_state_t st_r;
    ppfm_pkg::ppfm_state_t st_nxt;
    logic [ppfm_pkg::PIN_W-1:0] pin_sync;
    logic [7:0] k_s;
    logic [15:0] ad_s;
    logic [7:0] m_s;
    logic [5:0] p_s;
    logic [6:0] q_s;
    logic [7:0] s_s;
    logic [5:0] p_own;

    // per-bit select: owned bits take the peripheral value
    function automatic logic [15:0] pick(
        input logic [15:0] own,
        input logic [15:0] periph,
        input logic [15:0] gpio
    );
        pick = (own & periph) | (~own & gpio);
    endfunction

    ppfm_sync #(
        .W(ppfm_pkg::PIN_W)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_d({i_portk_pin, i_portad_pin, i_portm_pin, i_portp_pin, i_portq_pin, i_ports_pin}),
        .o_q(pin_sync)
    );

    assign {k_s, ad_s, m_s, p_s, q_s, s_s} = pin_sync;

    // pair ownership repeats per pwm channel
    genvar gi;
    generate
        for (gi = 0; gi < ppfm_pkg::P_W; gi++)
        begin : g_pair
            assign p_own[gi] = i_fault_protected_pwm_enable &
                (~i_fault_pwm_pair_mode | i_fault_pwm_pair_en[gi/2]);
        end
    endgenerate

    always_comb
    begin
        logic bus_k;
        logic [7:0] k_own;
        logic [7:0] k_po;
        logic [7:0] m_own;
        logic [7:0] m_po;
        logic [7:0] m_pe;
        logic [6:0] q_own;
        logic [7:0] s_own;
        logic [7:0] s_po;
        logic [7:0] s_pe;
        logic [15:0] ad_dig;
        bus_k = 1'b0;
        k_own = 8'h00;
        k_po = 8'h00;
        m_own = 8'h00;
        m_po = 8'h00;
        m_pe = 8'h00;
        q_own = 7'h00;
        s_own = 8'h00;
        s_po = 8'h00;
        s_pe = 8'h00;
        ad_dig = 16'h0000;
        st_nxt = st_r;

        // port K bus functions need both mode and enable
        bus_k = i_expanded_mode & i_ext_bus_portk_enable;
        k_own = {8{bus_k}};
        k_po[ppfm_pkg::K_ECS_BIT] = i_emulation_chip_select_n;
        k_po[ppfm_pkg::K_XCS_BIT] = i_external_chip_select_n;
        k_po[ppfm_pkg::K_ADDR_W-1:0] = i_extended_address_bits;
        st_nxt.k_out = 8'(pick({8'h00, k_own}, {8'h00, k_po}, {8'h00, i_portk_dout}));
        st_nxt.k_oe = 8'(pick({8'h00, k_own}, 16'hFFFF, {8'h00, i_portk_dir}));
        st_nxt.k_pu = {8{i_portk_pullup_enable}};

        // strap sampled once, on the first cycle after release
        if (!st_r.strap_done)
        begin
            st_nxt.strap_done = 1'b1;
            st_nxt.rom_en = i_expanded_mode ? k_s[ppfm_pkg::K_ECS_BIT]
                                            : ppfm_pkg::ROM_EN_SINGLE;
        end

        // analog pins never drive and read as zero
        ad_dig = i_portad_digital_en;
        st_nxt.ad_out = i_portad_dout;
        st_nxt.ad_oe = ad_dig & i_portad_dir;
        st_nxt.ad_din = ad_dig & ad_s;
        st_nxt.ad_last = ad_s;
        // a falling edge on an armed digital pin is a wake-up pulse
        st_nxt.wake = ad_dig & i_analog_port_wakeup_en & st_r.ad_last & ~ad_s;

        // open-drain two-wire lines: drive low only
        m_own[ppfm_pkg::M_SCL_BIT] = i_iic_enable;
        m_own[ppfm_pkg::M_SDA_BIT] = i_iic_enable;
        m_pe[ppfm_pkg::M_SCL_BIT] = i_iic_scl_drive_low;
        m_pe[ppfm_pkg::M_SDA_BIT] = i_iic_sda_drive_low;
        m_own[ppfm_pkg::M_TXD_BIT] = i_serial2_tx_enable;
        m_po[ppfm_pkg::M_TXD_BIT] = i_serial2_transmit;
        m_pe[ppfm_pkg::M_TXD_BIT] = 1'b1;
        m_own[ppfm_pkg::M_RXD_BIT] = i_serial2_rx_enable;
        // converter outputs are analog: digital driver stays off
        m_own[ppfm_pkg::M_DAC1_BIT] = i_converter1_enable;
        m_own[ppfm_pkg::M_DAC2_BIT] = i_converter2_enable;
        m_own[ppfm_pkg::M_GPIO_BIT] = 1'b0;
        st_nxt.m_out = 8'(pick({8'h00, m_own}, {8'h00, m_po}, {8'h00, i_portm_dout}));
        st_nxt.m_oe = 8'(pick({8'h00, m_own}, {8'h00, m_pe}, {8'h00, i_portm_dir}));
        st_nxt.iic_scl = i_iic_enable ? m_s[ppfm_pkg::M_SCL_BIT] : 1'b1;
        st_nxt.iic_sda = i_iic_enable ? m_s[ppfm_pkg::M_SDA_BIT] : 1'b1;
        st_nxt.rxd = i_serial2_rx_enable ? m_s[ppfm_pkg::M_RXD_BIT] : 1'b1;
        st_nxt.analog = {i_converter1_enable, i_converter2_enable};

        st_nxt.p_out = 6'(pick({10'h000, p_own}, {10'h000, i_fault_pwm_outputs},
                               {10'h000, i_portp_dout}));
        st_nxt.p_oe = 6'(pick({10'h000, p_own}, 16'hFFFF, {10'h000, i_portp_dir}));

        // status and fault pins are inputs while owned
        q_own = {{ppfm_pkg::Q_IS_W{i_current_status_enable}}, i_fault_input_enable};
        st_nxt.q_out = i_portq_dout;
        st_nxt.q_oe = ~q_own & i_portq_dir;
        st_nxt.is_n = i_current_status_enable ? q_s[6:ppfm_pkg::Q_IS_LSB] : 3'h7;
        st_nxt.fault = i_fault_input_enable & q_s[ppfm_pkg::Q_FAULT_W-1:0];

        // master drives clock and mosi, slave listens
        s_own[ppfm_pkg::S_SS_BIT] = i_spi_enable;
        s_own[ppfm_pkg::S_SCK_BIT] = i_spi_enable;
        s_own[ppfm_pkg::S_MOSI_BIT] = i_spi_enable;
        s_po[ppfm_pkg::S_SS_BIT] = i_spi_ss_n;
        s_po[ppfm_pkg::S_SCK_BIT] = i_spi_sck;
        s_po[ppfm_pkg::S_MOSI_BIT] = i_spi_mosi;
        s_pe[ppfm_pkg::S_SS_BIT] = i_spi_master & i_spi_ss_output_enable;
        s_pe[ppfm_pkg::S_SCK_BIT] = i_spi_master;
        s_pe[ppfm_pkg::S_MOSI_BIT] = i_spi_master;
        st_nxt.s_out = 8'(pick({8'h00, s_own}, {8'h00, s_po}, {8'h00, i_ports_dout}));
        st_nxt.s_oe = 8'(pick({8'h00, s_own}, {8'h00, s_pe}, {8'h00, i_ports_dir}));
        st_nxt.ss_n = (i_spi_enable & ~i_spi_master) ? s_s[ppfm_pkg::S_SS_BIT] : 1'b1;
        st_nxt.sck = (i_spi_enable & ~i_spi_master) ? s_s[ppfm_pkg::S_SCK_BIT] : 1'b0;
        st_nxt.mosi = (i_spi_enable & ~i_spi_master) ? s_s[ppfm_pkg::S_MOSI_BIT] : 1'b0;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            st_r <= '0;
            st_r.k_pu <= ppfm_pkg::K_PU_RST;
            st_r.ad_last <= ppfm_pkg::AD_LAST_RST;
            st_r.rom_en <= ppfm_pkg::ROM_EN_RST;
            st_r.iic_scl <= 1'b1;
            st_r.iic_sda <= 1'b1;
            st_r.rxd <= 1'b1;
            st_r.is_n <= 3'h7;
            st_r.ss_n <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_internal_rom_enable = st_r.rom_en;
    assign o_portk_pin = st_r.k_out;
    assign o_portk_oe = st_r.k_oe;
    assign o_portk_pullup = st_r.k_pu;
    assign o_portk_din = k_s;
    assign o_portad_pin = st_r.ad_out;
    assign o_portad_oe = st_r.ad_oe;
    assign o_portad_din = st_r.ad_din;
    assign o_key_wakeup = st_r.wake;
    assign o_portm_pin = st_r.m_out;
    assign o_portm_oe = st_r.m_oe;
    assign o_portm_din = m_s;
    assign o_iic_scl = st_r.iic_scl;
    assign o_iic_sda = st_r.iic_sda;
    assign o_serial2_receive = st_r.rxd;
    assign o_portm_analog_sel = st_r.analog;
    assign o_portp_pin = st_r.p_out;
    assign o_portp_oe = st_r.p_oe;
    assign o_portp_din = p_s;
    assign o_current_status_inputs_n = st_r.is_n;
    assign o_fault_inputs = st_r.fault;
    assign o_portq_pin = st_r.q_out;
    assign o_portq_oe = st_r.q_oe;
    assign o_portq_din = q_s;
    assign o_ports_pin = st_r.s_out;
    assign o_ports_oe = st_r.s_oe;
    assign o_ports_din = s_s;
    assign o_spi_ss_n = st_r.ss_n;
    assign o_spi_sck = st_r.sck;
    assign o_spi_mosi = st_r.mosi;
endmodule
`default_nettype wire

//--- src/ppfm_pkg.sv
/*
  Constants shared by the port pin function multiplexer.
  Assumes the port widths below match the pin ring of the device.
*/
package ppfm_pkg;
    localparam int K_W = 8;
    localparam int AD_W = 16;
    localparam int M_W = 8;
    localparam int P_W = 6;
    localparam int Q_W = 7;
    localparam int S_W = 8;
    localparam int PIN_W = K_W + AD_W + M_W + P_W + Q_W + S_W;
    // port K expanded bus positions
    localparam int K_ECS_BIT = 7;
    localparam int K_XCS_BIT = 6;
    localparam int K_ADDR_W = 6;
    // port M positions
    localparam int M_SCL_BIT = 7;
    localparam int M_SDA_BIT = 6;
    localparam int M_TXD_BIT = 5;
    localparam int M_RXD_BIT = 4;
    localparam int M_GPIO_BIT = 3;
    localparam int M_DAC1_BIT = 1;
    localparam int M_DAC2_BIT = 0;
    // port Q positions
    localparam int Q_IS_LSB = 4;
    localparam int Q_IS_W = 3;
    localparam int Q_FAULT_W = 4;
    // port S positions
    localparam int S_SS_BIT = 7;
    localparam int S_SCK_BIT = 6;
    localparam int S_MOSI_BIT = 5;
    // reset and strap values
    localparam logic [7:0] K_PU_RST = 8'hFF;
    localparam logic [15:0] AD_LAST_RST = 16'hFFFF;
    localparam logic ROM_EN_RST = 1'b1;
    localparam logic ROM_EN_SINGLE = 1'b1;

    typedef struct packed {
        logic [K_W-1:0] k_out;
        logic [K_W-1:0] k_oe;
        logic [K_W-1:0] k_pu;
        logic [AD_W-1:0] ad_out;
        logic [AD_W-1:0] ad_oe;
        logic [AD_W-1:0] ad_din;
        logic [AD_W-1:0] ad_last;
        logic [AD_W-1:0] wake;
        logic [M_W-1:0] m_out;
        logic [M_W-1:0] m_oe;
        logic [P_W-1:0] p_out;
        logic [P_W-1:0] p_oe;
        logic [Q_W-1:0] q_out;
        logic [Q_W-1:0] q_oe;
        logic [S_W-1:0] s_out;
        logic [S_W-1:0] s_oe;
        logic iic_scl;
        logic iic_sda;
        logic rxd;
        logic [1:0] analog;
        logic [Q_IS_W-1:0] is_n;
        logic [Q_FAULT_W-1:0] fault;
        logic ss_n;
        logic sck;
        logic mosi;
        logic rom_en;
        logic strap_done;
    } ppfm_state_t;

    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
    } ppfm_sync_t;
endpackage

//--- src/ppfm_sync.sv
/*
  Two-stage synchroniser for the raw pin levels.
  Assumes the inputs are asynchronous pins; the stages hold no reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ppfm_sync #(
    parameter int W = ppfm_pkg::PIN_W
) (
    // clock
    input wire logic i_core_clk,
    // data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    ppfm_pkg::ppfm_sync_t st_r;
    ppfm_pkg::ppfm_sync_t st_nxt;

    // the stage struct is sized by the package, so other widths cannot be served
    if (W != ppfm_pkg::PIN_W)
    begin : g_bad_width
        $error("sync width must equal the pin count");
    end

    // first stage feeds only the second stage
    always_comb
    begin
        st_nxt.s1 = i_d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge i_core_clk)
    begin
        st_r <= st_nxt;
    end

    assign o_q = st_r.s2;
endmodule
`default_nettype wire

//--- testbench/ppfm_props.sv
/*
  checker on the pin mux top ports
  assumes one clock and a synchronous active-low reset; bound below
*/
`timescale 1ns/1ps
`default_nettype none
module ppfm_props (
    input wire logic i_core_clk, i_resetn, i_expanded_mode, i_ext_bus_portk_enable,
    input wire logic i_portk_pullup_enable, i_emulation_chip_select_n,
    input wire logic i_external_chip_select_n, i_iic_enable, i_iic_scl_drive_low,
    input wire logic i_serial2_tx_enable, i_serial2_transmit, i_spi_enable, i_spi_master,
    input wire logic i_spi_sck, i_spi_mosi, i_fault_protected_pwm_enable, i_fault_pwm_pair_mode,
    input wire logic [5:0] i_extended_address_bits, i_fault_pwm_outputs, o_portp_pin, o_portp_oe,
    input wire logic [7:0] o_portk_pin, o_portk_oe, o_portk_pullup, i_portk_dout, i_portk_dir,
    input wire logic [7:0] o_portm_pin, o_portm_oe, i_portm_dout, i_portm_dir,
    input wire logic [7:0] o_ports_pin, o_ports_oe,
    input wire logic [6:0] o_portq_oe,
    input wire logic [15:0] o_key_wakeup
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    sequence s_bus_on;
        i_expanded_mode && i_ext_bus_portk_enable;
    endsequence
    sequence s_pulse_end;
        ##1 !o_key_wakeup[0];
    endsequence
    property p_bus;
        s_bus_on |=> o_portk_oe == 8'hFF && o_portk_pin == {$past(i_emulation_chip_select_n),
            $past(i_external_chip_select_n), $past(i_extended_address_bits)};
    endproperty
    a_bus: assert property (p_bus) else $error("k bus drive");
    property p_kgp;
        !(i_expanded_mode && i_ext_bus_portk_enable) |=> o_portk_oe == $past(i_portk_dir)
            && (o_portk_pin & o_portk_oe) == ($past(i_portk_dout) & $past(i_portk_dir));
    endproperty
    a_kgp: assert property (p_kgp) else $error("k gpio");
    property p_pull;
        1'b1 |=> o_portk_pullup == {8{$past(i_portk_pullup_enable)}};
    endproperty
    a_pull: assert property (p_pull) else $error("k pullup");
    property p_rst;
        $rose(i_resetn) |-> o_portm_oe == 8'h00 && o_portp_oe == 6'h00 && o_portq_oe == 7'h00
            && o_ports_oe == 8'h00 && o_portk_pullup == 8'hFF;
    endproperty
    a_rst: assert property (p_rst) else $error("reset pins");
    property p_m3;
        1'b1 |=> o_portm_oe[3] == $past(i_portm_dir[3])
            && (!o_portm_oe[3] || o_portm_pin[3] == $past(i_portm_dout[3]));
    endproperty
    a_m3: assert property (p_m3) else $error("m3 gpio");
    property p_iic;
        i_iic_enable |=> o_portm_oe[7] == $past(i_iic_scl_drive_low) && !o_portm_pin[7];
    endproperty
    a_iic: assert property (p_iic) else $error("scl pin");
    property p_tx;
        i_serial2_tx_enable |=> o_portm_oe[5] && o_portm_pin[5] == $past(i_serial2_transmit);
    endproperty
    a_tx: assert property (p_tx) else $error("tx pin");
    property p_pwm;
        i_fault_protected_pwm_enable && !i_fault_pwm_pair_mode |=> o_portp_oe == 6'h3F
            && o_portp_pin == $past(i_fault_pwm_outputs);
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm group");
    property p_spi;
        i_spi_enable && i_spi_master |=> o_ports_oe[6:5] == 2'b11
            && o_ports_pin[6:5] == {$past(i_spi_sck), $past(i_spi_mosi)};
    endproperty
    a_spi: assert property (p_spi) else $error("spi master");
    property p_wake;
        $rose(o_key_wakeup[0]) |-> s_pulse_end;
    endproperty
    a_wake: assert property (p_wake) else $error("wake pulse");
endmodule
bind ppfm_top ppfm_props i_props (.*);
`default_nettype wire

//--- testbench/ppfm_board.sv
/*
  board model: level seen on each pin
  assumes device drive wins, then board drive, then pull-up
*/
`timescale 1ns/1ps
`default_nettype none
module ppfm_board #(
    parameter int W = 8
) (
    input wire logic i_core_clk,
    input wire logic [W-1:0] i_oe, i_out, i_drv_en, i_drv, i_pu,
    output logic [W-1:0] o_level
);
    logic [W-1:0] last_r = '0;
    logic [W-1:0] dev_on;
    // a floating pin flips each cycle so a stale level never reads as good
    always_ff @(posedge i_core_clk)
    begin
        last_r <= o_level;
    end
    always_comb
    begin
        dev_on = '0;
        // before the first reset edge the enables are unknown: treat them as released
        for (int b = 0; b < W; b++)
        begin
            dev_on[b] = (i_oe[b] === 1'b1);
        end
        o_level = (dev_on & i_out) | (~dev_on & i_drv_en & i_drv)
            | (~dev_on & ~i_drv_en & (i_pu | ~last_r));
    end
endmodule
`default_nettype wire

//--- testbench/ppfm_top_tb.sv
/*
  testbench for the pin mux
  assumes board model on ports k, m, s; other pins driven here
*/
`timescale 1ns/1ps
`default_nettype none
module ppfm_top_tb;
    logic i_core_clk, i_resetn, i_expanded_mode, i_ext_bus_portk_enable, i_portk_pullup_enable;
    logic i_emulation_chip_select_n, i_external_chip_select_n, i_iic_enable, i_iic_scl_drive_low;
    logic i_iic_sda_drive_low, i_serial2_tx_enable, i_serial2_transmit, i_serial2_rx_enable;
    logic i_converter1_enable, i_converter2_enable, i_fault_protected_pwm_enable, i_spi_mosi;
    logic i_fault_pwm_pair_mode, i_current_status_enable, i_spi_enable, i_spi_master;
    logic i_spi_ss_output_enable, i_spi_ss_n, i_spi_sck, o_internal_rom_enable, o_iic_scl;
    logic o_iic_sda, o_serial2_receive, o_spi_ss_n, o_spi_sck, o_spi_mosi;
    logic [1:0] o_portm_analog_sel;
    logic [2:0] i_fault_pwm_pair_en, o_current_status_inputs_n;
    logic [3:0] i_fault_input_enable, o_fault_inputs;
    logic [5:0] i_extended_address_bits, i_portp_pin, i_portp_dout, i_portp_dir;
    logic [5:0] i_fault_pwm_outputs, o_portp_pin, o_portp_oe, o_portp_din;
    logic [6:0] i_portq_pin, i_portq_dout, i_portq_dir, o_portq_pin, o_portq_oe, o_portq_din;
    logic [7:0] i_portk_pin, i_portk_dout, i_portk_dir, i_portm_pin, i_portm_dout, i_portm_dir;
    logic [7:0] i_ports_pin, i_ports_dout, i_ports_dir, o_portk_pin, o_portk_oe, o_portk_din;
    logic [7:0] o_portk_pullup, o_portm_pin, o_portm_oe, o_portm_din;
    logic [7:0] o_ports_pin, o_ports_oe, o_ports_din;
    logic [15:0] i_portad_pin, i_portad_dout, i_portad_dir, i_portad_digital_en;
    logic [15:0] i_analog_port_wakeup_en, o_portad_pin, o_portad_oe, o_portad_din, o_key_wakeup;
    logic [23:0] bd_en, bd_v;
    int bad_count, tests_run, cycles, n;
    ppfm_top i_dut (.*);
    ppfm_board #(.W(24)) i_board (
        .i_core_clk(i_core_clk),
        .i_oe({o_portk_oe, o_portm_oe, o_ports_oe}),
        .i_out({o_portk_pin, o_portm_pin, o_ports_pin}),
        .i_drv_en(bd_en),
        .i_drv(bd_v),
        .i_pu({o_portk_pullup, 8'hC0, 8'h00}),
        .o_level({i_portk_pin, i_portm_pin, i_ports_pin})
    );
    always #10 i_core_clk = ~i_core_clk;
    task automatic ck(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic nxt;
        @(posedge i_core_clk);
        #1;
    endtask
    task automatic end_sim;
        $display("counts tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // generous ceiling: the sequence needs well under a hundred cycles
    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 400)
        begin
            bad_count++;
            end_sim;
        end
    end
    initial
    begin
        {i_core_clk, i_resetn, i_ext_bus_portk_enable, i_emulation_chip_select_n,
            i_external_chip_select_n, i_iic_enable, i_iic_scl_drive_low, i_iic_sda_drive_low,
            i_serial2_tx_enable, i_serial2_transmit, i_serial2_rx_enable, i_converter1_enable,
            i_converter2_enable, i_fault_protected_pwm_enable, i_fault_pwm_pair_mode,
            i_current_status_enable, i_spi_enable, i_spi_master, i_spi_ss_output_enable,
            i_spi_ss_n, i_spi_sck, i_spi_mosi, i_fault_pwm_pair_en, i_fault_input_enable,
            i_extended_address_bits, i_portp_pin, i_portp_dout, i_fault_pwm_outputs, i_portq_pin,
            i_portq_dout, i_portad_dout, i_portad_dir, i_portad_digital_en,
            i_analog_port_wakeup_en, i_ports_dout, bd_v} = '0;
        {i_expanded_mode, i_portk_pullup_enable, i_portk_dir, i_portm_dir, i_ports_dir,
            i_portp_dir, i_portq_dir, i_portad_pin} = '1;
        i_portk_dout = 8'h3C;
        i_portm_dout = 8'h08;
        bd_en = 24'h800000;
        repeat (2) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        #1;
        ck("oe in reset", {o_portm_oe, o_portp_oe, o_portq_oe, o_ports_oe}, 24'h0);
        ck("k pullup", o_portk_pullup, 8'hFF);
        nxt;
        ck("rom strap", o_internal_rom_enable, 1'b0);
        ck("k gpio", {o_portk_oe, o_portk_pin}, 16'hFF3C);
        ck("m3", {o_portm_oe[3], o_portm_pin[3]}, 2'b11);
        @(posedge i_core_clk);
        i_portk_pullup_enable <= 1'b0;
        i_ext_bus_portk_enable <= 1'b1;
        i_external_chip_select_n <= 1'b1;
        i_extended_address_bits <= 6'h2A;
        nxt;
        ck("k pullup off", o_portk_pullup, 8'h00);
        ck("k bus", {o_portk_oe, o_portk_pin}, 16'hFF6A);
        @(posedge i_core_clk);
        i_expanded_mode <= 1'b0;
        nxt;
        ck("k single", {o_portk_oe, o_portk_pin}, 16'hFF3C);
        ck("k din", o_portk_din, 8'h6A);
        $display("test port k done");
        @(posedge i_core_clk);
        {i_iic_enable, i_iic_scl_drive_low, i_serial2_tx_enable} <= 3'b111;
        {i_serial2_transmit, i_serial2_rx_enable} <= 2'b11;
        {i_converter1_enable, i_converter2_enable} <= 2'b11;
        bd_en <= 24'h001000;
        nxt;
        ck("m oe", o_portm_oe, 8'hAC);
        ck("m out", o_portm_pin & o_portm_oe, 8'h28);
        ck("dac sel", o_portm_analog_sel, 2'b11);
        repeat (3) nxt;
        ck("m in", {o_iic_scl, o_iic_sda, o_serial2_receive}, 3'b010);
        ck("m din", o_portm_din[7:2], 6'h1A);
        $display("test port m done");
        @(posedge i_core_clk);
        i_fault_protected_pwm_enable <= 1'b1;
        i_fault_pwm_outputs <= 6'h15;
        i_portp_dir <= 6'h00;
        nxt;
        ck("p group", {o_portp_oe, o_portp_pin}, {6'h3F, 6'h15});
        @(posedge i_core_clk);
        i_fault_pwm_pair_mode <= 1'b1;
        i_fault_pwm_pair_en <= 3'b010;
        nxt;
        ck("p pair", {o_portp_oe, o_portp_pin & o_portp_oe}, {6'h0C, 6'h04});
        @(posedge i_core_clk);
        i_current_status_enable <= 1'b1;
        i_fault_input_enable <= 4'hF;
        i_portq_pin <= 7'h56;
        i_portp_pin <= 6'h2D;
        repeat (3) nxt;
        ck("q on", {o_portq_oe, o_current_status_inputs_n, o_fault_inputs}, 14'h56);
        ck("q din", o_portq_din, 7'h56);
        ck("p din", o_portp_din, 6'h2D);
        @(posedge i_core_clk);
        i_current_status_enable <= 1'b0;
        i_fault_input_enable <= 4'h0;
        i_portq_dout <= 7'h2B;
        nxt;
        ck("q off", {o_portq_oe, o_current_status_inputs_n, o_fault_inputs}, 14'h3FF0);
        ck("q pin", o_portq_pin, 7'h2B);
        $display("test ports p q done");
        @(posedge i_core_clk);
        {i_spi_enable, i_spi_master, i_spi_ss_output_enable, i_spi_sck} <= 4'hF;
        i_ports_dir <= 8'h00;
        nxt;
        ck("spi master", {o_ports_oe, o_ports_pin[7:5]}, {8'hE0, 3'b010});
        @(posedge i_core_clk);
        i_spi_master <= 1'b0;
        bd_en <= 24'h0000E0;
        bd_v <= 24'h000060;
        repeat (4) nxt;
        ck("spi slave", {o_ports_oe[7:5], o_spi_ss_n, o_spi_sck, o_spi_mosi}, 6'h03);
        ck("s din", o_ports_din[7:5], 3'b011);
        $display("test port s done");
        @(posedge i_core_clk);
        i_portad_digital_en <= 16'hFFFF;
        i_analog_port_wakeup_en <= 16'h0001;
        i_portad_dir <= 16'h00F0;
        i_portad_dout <= 16'h1234;
        nxt;
        ck("ad out", {o_portad_oe, o_portad_pin[7:0] & o_portad_oe[7:0]}, 24'h00F030);
        @(posedge i_core_clk);
        i_portad_pin <= 16'hFFFE;
        #1;
        n = 0;
        while (o_key_wakeup !== 16'h0001 && n < 8)
        begin
            nxt;
            n++;
        end
        ck("wake", o_key_wakeup, 16'h0001);
        ck("wake delay", n, 32'h3);
        ck("ad din", o_portad_din, 16'hFFFE);
        nxt;
        ck("wake end", o_key_wakeup, 16'h0000);
        // one more edge so the pulse-end assertion finishes its attempt
        nxt;
        $display("test port ad done");
        end_sim;
    end
endmodule
`default_nettype wire
